// File: src/lpi_pkg.sv
// Constants and types shared by the load port handoff interlock.
package lpi_pkg;
    // -------------------------------------------------------------------
    // Timing
    // -------------------------------------------------------------------
    localparam int unsigned LPI_CLK_HZ = 50000000;
    localparam int unsigned LPI_TP3_S = 60;
    localparam int unsigned LPI_TICK_HZ = 1000;
    localparam int unsigned LPI_TICK_DIV = LPI_CLK_HZ / LPI_TICK_HZ;
    localparam int unsigned LPI_TP3_TICKS = LPI_TP3_S * LPI_TICK_HZ;
    localparam int unsigned LPI_CNT_W = 32;
    // -------------------------------------------------------------------
    // Handshake states
    // -------------------------------------------------------------------
    typedef enum logic [2:0] {
        LPI_IDLE,
        LPI_REQ,
        LPI_READY,
        LPI_XFER,
        LPI_DONE,
        LPI_COMPLETE,
        LPI_ERROR
    } lpi_state_t;
endpackage

// File: src/lpi_sync.sv
// Two flip-flop level synchroniser for asynchronous inputs.
`timescale 1ns/10ps
`default_nettype none
module lpi_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Data
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_r;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            meta_r <= '0;
            sync_out <= '0;
        end else begin
            meta_r <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule
`default_nettype wire

// File: src/lpi_interlock.sv
// Passive load port handoff interlock with sensor checks and emergency stop.
//
// Summary of operation
// - Load: presence without placement keeps load request high, no completion.
// - Partial sensor state lasting to transfer wait expiry raises timeout error.
// - Unload: placement gone, presence kept keeps unload request high.
// - Unload: presence gone, placement kept keeps unload request high.
// - Emergency stop during unload wait drops emergency ok.
// - Without emergency drop and no removal, unload wait expiry raises timeout.
// - Emergency ok returns once the emergency stop clears.
// - Available, select and valid lead to load or unload request by port state.
// - Request drops after busy once carrier placed or removed with sensors agreeing.
// - Ready drops after complete with busy and transfer request low.
`timescale 1ns/10ps
`default_nettype none
module lpi_interlock
    import lpi_pkg::*;
#(
    parameter int unsigned TICK_DIV = LPI_TICK_DIV,
    parameter int unsigned TP3_TICKS = LPI_TP3_TICKS
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Handshake inputs from the active party
    input wire logic carrier_select_0,
    input wire logic carrier_select_1,
    input wire logic valid,
    input wire logic transfer_request,
    input wire logic busy,
    input wire logic complete,
    // Port sensors and local stop
    input wire logic presence_sensor,
    input wire logic placement_sensor,
    input wire logic emergency_stop_button,
    input wire logic error_clear,
    // Handshake outputs
    output logic load_request,
    output logic unload_request,
    output logic ready,
    output logic handoff_available,
    output logic emergency_ok,
    // Status
    output logic transfer_wait_timeout
);
    initial begin
        if (TICK_DIV < 1 || TP3_TICKS < 1 || TP3_TICKS >= 2**(LPI_CNT_W-1)) begin
            $error("lpi_interlock: bad timer parameters");
        end
    end

    // -------------------------------------------------------------------
    // Input synchronisation
    // -------------------------------------------------------------------
    logic [7:0] raw_in;
    logic [7:0] sync_in;
    assign raw_in = {carrier_select_0, carrier_select_1, valid, transfer_request,
                     busy, complete, presence_sensor, placement_sensor};
    logic cs0_s, cs1_s, valid_s, treq_s, busy_s, complete_s, pres_s, plac_s, estop_s;
    assign {cs0_s, cs1_s, valid_s, treq_s, busy_s, complete_s, pres_s, plac_s} = sync_in;

    lpi_sync #(.WIDTH(8)) u_sync_link (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .async_in(raw_in),
        .sync_out(sync_in)
    );
    lpi_sync #(.WIDTH(1)) u_sync_stop (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .async_in(emergency_stop_button),
        .sync_out(estop_s)
    );

    // -------------------------------------------------------------------
    // Sensor evaluation
    // -------------------------------------------------------------------
    logic full_s, empty_s, partial_s;
    assign full_s = pres_s && plac_s;
    assign empty_s = !pres_s && !plac_s;
    assign partial_s = pres_s ^ plac_s;

    // -------------------------------------------------------------------
    // Handshake state machine
    // -------------------------------------------------------------------
    lpi_state_t state_r;
    logic unload_r;
    logic tick_r;
    logic [LPI_CNT_W-1:0] div_r;
    logic [LPI_CNT_W-1:0] wait_r;
    logic waiting;
    logic expired;
    assign waiting = (state_r == LPI_XFER) && emergency_ok;
    assign expired = waiting && (wait_r >= TP3_TICKS[LPI_CNT_W-1:0]);

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            div_r <= '0;
            tick_r <= 1'b0;
        end else if (div_r >= TICK_DIV[LPI_CNT_W-1:0] - 32'h1) begin
            div_r <= '0;
            tick_r <= 1'b1;
        end else begin
            div_r <= div_r + 32'h1;
            tick_r <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n || !waiting) begin
            wait_r <= '0;
        end else if (tick_r && !expired) begin
            wait_r <= wait_r + 32'h1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state_r <= LPI_IDLE;
            unload_r <= 1'b0;
        end else if (!emergency_ok) begin
            state_r <= LPI_IDLE;
        end else begin
            unique case (state_r)
                LPI_IDLE: begin
                    if (cs0_s && !cs1_s && valid_s && (full_s || empty_s)) begin
                        state_r <= LPI_REQ;
                        unload_r <= full_s;
                    end
                end
                LPI_REQ: begin
                    if (!valid_s) begin
                        state_r <= LPI_IDLE;
                    end else if (treq_s) begin
                        state_r <= LPI_READY;
                    end
                end
                LPI_READY: begin
                    if (busy_s) begin
                        state_r <= LPI_XFER;
                    end
                end
                LPI_XFER: begin
                    if (expired) begin
                        state_r <= LPI_ERROR;
                    end else if (unload_r ? empty_s : full_s) begin
                        state_r <= LPI_DONE;
                    end
                end
                LPI_DONE: begin
                    if (complete_s && !busy_s && !treq_s) begin
                        state_r <= LPI_COMPLETE;
                    end
                end
                LPI_COMPLETE: begin
                    if (!complete_s && !valid_s && !cs0_s) begin
                        state_r <= LPI_IDLE;
                    end
                end
                LPI_ERROR: begin
                    if (error_clear) begin
                        state_r <= LPI_IDLE;
                    end
                end
            endcase
        end
    end

    // -------------------------------------------------------------------
    // Registered outputs
    // -------------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            emergency_ok <= 1'b0;
        end else begin
            emergency_ok <= !estop_s;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            load_request <= 1'b0;
            unload_request <= 1'b0;
            ready <= 1'b0;
            handoff_available <= 1'b0;
            transfer_wait_timeout <= 1'b0;
        end else begin
            load_request <= (state_r inside {LPI_REQ, LPI_READY, LPI_XFER}) && !unload_r;
            unload_request <= (state_r inside {LPI_REQ, LPI_READY, LPI_XFER}) && unload_r;
            ready <= (state_r inside {LPI_READY, LPI_XFER, LPI_DONE});
            handoff_available <= (state_r != LPI_ERROR) && emergency_ok;
            if (expired) begin
                transfer_wait_timeout <= 1'b1;
            end else if (error_clear) begin
                transfer_wait_timeout <= 1'b0;
            end
        end
    end

    // -------------------------------------------------------------------
    // Assertions
    // -------------------------------------------------------------------
    estop_drop_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        estop_s |=> !emergency_ok)
        else $error("emergency ok not dropped on stop");
    estop_restore_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        $fell(estop_s) |=> emergency_ok)
        else $error("emergency ok not restored");
    load_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (state_r == LPI_XFER && !unload_r && partial_s && emergency_ok) |=> load_request)
        else $error("load request dropped on partial sensors");
    unload_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (state_r == LPI_XFER && unload_r && pres_s && emergency_ok) |=> unload_request)
        else $error("unload request dropped with presence active");
    unload_place_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (state_r == LPI_XFER && unload_r && plac_s && emergency_ok) |=> unload_request)
        else $error("unload request dropped with placement active");
    timeout_set_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        expired |=> transfer_wait_timeout && state_r == LPI_ERROR)
        else $error("timeout not raised on expiry");
    unload_timeout_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (expired && unload_r) |=> ##1 !unload_request)
        else $error("unload timeout not handled");
    request_answer_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (state_r == LPI_IDLE && emergency_ok && cs0_s && !cs1_s && valid_s && empty_s)
        |=> ##1 load_request)
        else $error("no load request on select and valid");
    ready_drop_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (state_r == LPI_DONE && emergency_ok && complete_s && !busy_s && !treq_s) |=> ##1 !ready)
        else $error("ready not dropped after complete");
endmodule
`default_nettype wire

// File: tb/lpi_act.sv
// Model of the active transfer party driving the handshake lines.
`timescale 1ns/10ps
`default_nettype none
module lpi_act (
    // Clock and emergency line
    input wire logic core_clk,
    input wire logic emergency_ok,
    // Line pattern requested by the bench
    input wire logic [5:0] cmd,
    // Handshake lines
    output logic cs0,
    output logic cs1,
    output logic valid,
    output logic treq,
    output logic busy,
    output logic complete
);
    logic [5:0] last_cmd = 6'h00;
    initial {cs0, cs1, valid, treq, busy, complete} = 6'h00;
    // Applies a new pattern to all lines together one edge after it is asked for.
    // Releases cs0, valid, treq and busy once emergency ok is seen low and keeps them released.
    always @(posedge core_clk) begin
        if (emergency_ok !== 1'b1) begin
            {cs0, valid, treq, busy} <= 4'h0;
        end else if (cmd != last_cmd) begin
            {cs0, cs1, valid, treq, busy, complete} <= cmd;
        end
        last_cmd <= cmd;
    end
endmodule
`default_nettype wire

// File: tb/tb.sv
// Self-checking testbench for the load port handoff interlock.
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic pres = 1'b0;
    logic plac = 1'b0;
    logic stop = 1'b0;
    logic eclr = 1'b0;
    logic [5:0] cmd = 6'h00;
    logic cs0, cs1, vld, treq, bsy, cmp, lreq, ureq, rdy, hoa, eok, tmo;
    int err_count = 0;
    int cmp_count = 0;
    int cyc = 0;
    always #10 core_clk = ~core_clk;
    lpi_act u_act (.core_clk(core_clk), .emergency_ok(eok), .cmd(cmd), .cs0(cs0), .cs1(cs1),
        .valid(vld), .treq(treq), .busy(bsy), .complete(cmp));
    lpi_interlock #(.TICK_DIV(2), .TP3_TICKS(10)) i_lpi_interlock (
        .core_clk(core_clk), .rst_n(rst_n), .carrier_select_0(cs0),
        .carrier_select_1(cs1), .valid(vld), .transfer_request(treq), .busy(bsy),
        .complete(cmp), .presence_sensor(pres), .placement_sensor(plac),
        .emergency_stop_button(stop), .error_clear(eclr), .load_request(lreq),
        .unload_request(ureq), .ready(rdy), .handoff_available(hoa),
        .emergency_ok(eok), .transfer_wait_timeout(tmo));
    task wt(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    // Hands the partner model a new line pattern just after an edge.
    task drive(input logic [5:0] v);
        @(posedge core_clk);
        cmd <= v;
    endtask
    task chk(input string nm, input logic seen, input logic exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %s expected %b seen %b", nm, exp, seen);
        end
    endtask
    task sens(input logic p, input logic q);
        @(posedge core_clk);
        pres <= p;
        plac <= q;
    endtask
    task results();
        $display("checks %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Brings the handshake up to the transfer wait.
    task setup(input logic ld);
        chk("handoff_available", hoa, 1'b1);
        drive(6'h28);
        wt(6);
        chk("load_request", lreq, ld);
        chk("unload_request", ureq, !ld);
        drive(6'h2C);
        wt(6);
        chk("ready", rdy, 1'b1);
        drive(6'h2E);
        wt(2);
    endtask
    task finish_xfer();
        drive(6'h29);
        wt(6);
        chk("ready", rdy, 1'b0);
        drive(6'h00);
        wt(6);
    endtask
    task t_load();
        setup(1'b1);
        sens(1'b1, 1'b1);
        wt(6);
        chk("load_request", lreq, 1'b0);
        finish_xfer();
        $display("test load done");
    endtask
    task t_unload();
        setup(1'b0);
        sens(1'b0, 1'b0);
        wt(6);
        chk("unload_request", ureq, 1'b0);
        finish_xfer();
        $display("test unload done");
    endtask
    // Partial sensor state held through the transfer wait.
    task t_partial(input logic ld, input logic p, input logic q);
        sens(!ld, !ld);
        wt(6);
        setup(ld);
        sens(p, q);
        wt(8);
        chk("held_request", ld ? lreq : ureq, 1'b1);
        chk("timeout", tmo, 1'b0);
        wt(30);
        chk("timeout", tmo, 1'b1);
        chk("held_request", lreq | ureq, 1'b0);
        @(posedge core_clk);
        eclr <= 1'b1;
        @(posedge core_clk);
        eclr <= 1'b0;
        drive(6'h00);
        wt(6);
        chk("timeout", tmo, 1'b0);
        $display("test partial done");
    endtask
    task t_estop();
        sens(1'b1, 1'b1);
        wt(6);
        setup(1'b0);
        @(posedge core_clk);
        stop <= 1'b1;
        wt(6);
        chk("emergency_ok", eok, 1'b0);
        chk("unload_request", ureq, 1'b0);
        chk("busy", bsy, 1'b0);
        chk("carrier_select_0", cs0, 1'b0);
        @(posedge core_clk);
        stop <= 1'b0;
        wt(6);
        chk("emergency_ok", eok, 1'b1);
        wt(2);
        chk("handoff_available", hoa, 1'b1);
        $display("test estop done");
    endtask
    // Select with the second select bit high is refused; valid dropping aborts.
    task t_refuse();
        sens(1'b0, 1'b0);
        drive(6'h38);
        wt(8);
        chk("load_request", lreq, 1'b0);
        chk("unload_request", ureq, 1'b0);
        drive(6'h28);
        wt(7);
        chk("load_request", lreq, 1'b1);
        drive(6'h20);
        wt(7);
        chk("load_request", lreq, 1'b0);
        drive(6'h00);
        wt(6);
        $display("test refuse done");
    endtask
    // Reset taken in the middle of a handshake clears it and restarts cleanly.
    task t_reset();
        drive(6'h28);
        wt(7);
        chk("load_request", lreq, 1'b1);
        @(posedge core_clk);
        rst_n <= 1'b0;
        wt(6);
        chk("load_request", lreq, 1'b0);
        chk("handoff_available", hoa, 1'b0);
        chk("emergency_ok", eok, 1'b0);
        chk("carrier_select_0", cs0, 1'b0);
        drive(6'h00);
        rst_n <= 1'b1;
        wt(8);
        chk("emergency_ok", eok, 1'b1);
        chk("handoff_available", hoa, 1'b1);
        chk("load_request", lreq, 1'b0);
        $display("test reset done");
    endtask
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 3000) begin
            err_count++;
            results();
        end
    end
    initial begin
        wt(6);
        rst_n <= 1'b1;
        wt(8);
        chk("emergency_ok", eok, 1'b1);
        t_load();
        t_unload();
        t_partial(1'b1, 1'b1, 1'b0);
        t_partial(1'b0, 1'b1, 1'b0);
        t_partial(1'b0, 1'b0, 1'b1);
        t_estop();
        t_refuse();
        t_reset();
        results();
    end
endmodule
`default_nettype wire
